/* File: inc/ebus_consts.vh */
// constants for the external bus access sequencer
// Overview of operation
// - byte-write: upper/lower write strobes, read strobe
// - byte-select: byte selects, write and output strobes
// - strobe type chosen per 16-bit chip select
// - reset cs0: seven waits, width from boot pin
// - reset cs0: byte-write type, zero float time
// - cs0 wait count applies now, base after remap
// - one read protocol for all, standard default
// - standard read: strobe low second half only
// - write strobes low second half of cycle
// - early read: strobe from start, released between reads
// - early: write then read adds one wait
// - no early wait otherwise
// - early waits never stall internal transfers
// - write data framed by pin-level write strobe
// - count used only when enabled, n waits
// - write strobe half cycle, plus one per wait
// - float waits after read before write/other cs
// - float time counts during internal accesses
// - no float waits internal or same-memory reads
// - wait request low freezes whole sequencer
// - chip select change adds one wait unless waited
`ifndef EBUS_CONSTS_VH
`define EBUS_CONSTS_VH
`define CS_COUNT        8
`define CS_IDX_W        3
`define ADDR_W          24
`define DATA_W          16
`define WAIT_W          3
`define FLOAT_W         3
`define CS0_RESET_WAITS 3'h7
`define CS0_RESET_FLOAT 3'h0
`define FIFO_WIDTH      46
`define FIFO_DEPTH      32
`define FIFO_AW         5
`endif

/* File: rtl/ebus_fifo.v */
// request fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ebus_fifo #(
  parameter WIDTH = 43,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk_i,
  input  wire             resetn_i,
  input  wire             ce_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire            empty = (wr_q == rd_q);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (in_valid_i && !full) begin
        mem_q[wr_q[AW-1:0]] <= in_data_i;
        wr_q                <= wr_q + 1'b1;
      end
      if (out_ready_i && !empty)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule // ebus_fifo
`default_nettype wire

/* File: rtl/ebus_access.v */
// external bus access sequencer: strobes, chip selects and wait states
`timescale 1ns/1ps
`default_nettype none
`include "ebus_consts.vh"
module ebus_access (
  input  wire                 mclk_i,
  input  wire                 resetn_i,
  input  wire                 ce_i,
  input  wire                 boot_width_pin_i,
  input  wire                 remap_done_i,
  input  wire                 read_protocol_select_i,
  input  wire [7:0]           cfg_wse_i,
  input  wire [23:0]          cfg_nws_i,
  input  wire [23:0]          cfg_tdf_i,
  input  wire [7:0]           cfg_bat_i,
  input  wire [7:0]           cfg_wide_i,
  input  wire                 cs0_cfg_written_i,
  input  wire                 req_valid_i,
  output wire                 req_ready_o,
  input  wire                 req_write_i,
  input  wire [2:0]           req_cs_i,
  input  wire [23:0]          req_addr_i,
  input  wire [15:0]          req_wdata_i,
  input  wire [1:0]           req_be_i,
  input  wire                 int_access_i,
  output wire                 int_ready_o,
  output reg                  done_o,
  output reg  [15:0]          rdata_o,
  output reg                  cs0_wide_o,
  output reg                  cs0_base_active_o,
  output reg  [7:0]           chip_select_low_o,
  output reg  [23:0]          addr_o,
  output reg                  lower_byte_select_o,
  output reg                  upper_byte_select_o,
  output reg                  read_strobe_o,
  output reg                  output_enable_strobe_o,
  output reg                  lower_write_strobe_o,
  output reg                  upper_write_strobe_o,
  output reg                  write_strobe_o,
  input  wire                 write_strobe_pin_i,
  input  wire [15:0]          data_i,
  output reg  [15:0]          data_o,
  output reg                  data_oe_o,
  input  wire                 wait_request_n_i
);
  localparam S_IDLE  = 4'b0001;
  localparam S_PRE   = 4'b0010;
  localparam S_XFER  = 4'b0100;
  localparam S_DONE  = 4'b1000;

  // three stage synchronisers for pins
  reg [2:0] wait_sy_q;
  reg [2:0] wes_sy_q;
  reg       wait_low_q;
  reg       wes_low_q;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      wait_sy_q  <= 3'h7;
      wes_sy_q   <= 3'h7;
      wait_low_q <= 1'b0;
      wes_low_q  <= 1'b0;
    end else if (ce_i) begin
      wait_sy_q <= {wait_sy_q[1:0], wait_request_n_i};
      wes_sy_q  <= {wes_sy_q[1:0], write_strobe_pin_i};
      if (wait_sy_q[1] == wait_sy_q[2])
        wait_low_q <= ~wait_sy_q[2];
      if (wes_sy_q[1] == wes_sy_q[2])
        wes_low_q <= ~wes_sy_q[2];
    end
  end
  wire run = ce_i & ~wait_low_q;

  // cs0 boot config caught at reset release
  reg       boot_q;
  reg       cs0_wse_q;
  reg [2:0] cs0_nws_q;
  reg [2:0] cs0_tdf_q;
  reg       cs0_bat_q;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      boot_q            <= 1'b1;
      cs0_wse_q         <= 1'b1;
      cs0_nws_q         <= `CS0_RESET_WAITS;
      cs0_tdf_q         <= `CS0_RESET_FLOAT;
      cs0_bat_q         <= 1'b0;
      cs0_wide_o        <= 1'b0;
      cs0_base_active_o <= 1'b0;
    end else if (ce_i) begin
      if (boot_q) begin
        boot_q     <= 1'b0;
        cs0_wide_o <= ~boot_width_pin_i;
      end
      if (cs0_cfg_written_i) begin
        // wait count takes effect now; base only after remap
        cs0_wse_q  <= cfg_wse_i[0];
        cs0_nws_q  <= cfg_nws_i[2:0];
        cs0_tdf_q  <= cfg_tdf_i[2:0];
        cs0_bat_q  <= cfg_bat_i[0];
        cs0_wide_o <= cfg_wide_i[0];
      end
      if (remap_done_i)
        cs0_base_active_o <= 1'b1;
    end
  end

  wire [`FIFO_WIDTH-1:0] fifo_out;
  wire        fifo_valid;
  reg         fifo_pop;
  ebus_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .mclk_i      (mclk_i),
    .resetn_i    (resetn_i),
    .ce_i        (run),
    .in_valid_i  (req_valid_i),
    .in_ready_o  (req_ready_o),
    .in_data_i   ({req_write_i, req_cs_i, req_addr_i, req_wdata_i, req_be_i}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );
  // lane enables travel in the fifo word so queued requests keep their own
  reg        fl_seen_q;
  reg        wes_seen_q;

  // per-cs configuration view, cs0 from the boot copy
  reg [3:0] st_q;
  reg       wr_q;
  reg [2:0] cs_q;
  reg [3:0] cnt_q;
  reg [2:0] float_q;
  reg [2:0] last_cs_q;
  reg       last_rd_q;
  reg       last_wr_q;
  reg       any_ext_q;
  reg       half_q;
  reg [1:0] be_q;
  wire [2:0] f_cs    = fifo_out[44:42];
  wire       f_wr    = fifo_out[45];
  wire       c_wse   = (f_cs == 3'h0) ? cs0_wse_q : cfg_wse_i[f_cs];
  wire [2:0] c_nws   = (f_cs == 3'h0) ? cs0_nws_q : cfg_nws_i[f_cs*3 +: 3];
  wire       cur_bat = (cs_q == 3'h0) ? cs0_bat_q : cfg_bat_i[cs_q];
  wire       cur_wide= (cs_q == 3'h0) ? cs0_wide_o : cfg_wide_i[cs_q];
  wire [2:0] cur_tdf = (cs_q == 3'h0) ? cs0_tdf_q : cfg_tdf_i[cs_q*3 +: 3];
  wire       byte_sel= cur_wide & cur_bat;
  wire       cs_chg  = any_ext_q && (f_cs != last_cs_q);
  // float only after a read, before write or other memory
  wire       need_fl = last_rd_q && (f_wr || cs_chg) && (float_q != 3'h0);
  wire       early_w = read_protocol_select_i && last_wr_q && !f_wr;
  // a float wait already spent between the two memories replaces this one
  wire       cs_w    = cs_chg && !fl_seen_q;
  // internal accesses proceed regardless of float or early waits
  assign int_ready_o = run & int_access_i;

  always @* begin
    fifo_pop = 1'b0;
    if (st_q == S_IDLE && fifo_valid && !need_fl && !int_access_i)
      fifo_pop = 1'b1;
  end

  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q      <= S_IDLE;
      wr_q      <= 1'b0;
      cs_q      <= 3'h0;
      cnt_q     <= 4'h0;
      float_q   <= 3'h0;
      last_cs_q <= 3'h0;
      last_rd_q <= 1'b0;
      last_wr_q <= 1'b0;
      any_ext_q <= 1'b0;
      half_q    <= 1'b0;
      be_q      <= 2'h3;
      fl_seen_q <= 1'b0;
      done_o    <= 1'b0;
      rdata_o   <= 16'h0000;
      addr_o    <= 24'h000000;
      data_o    <= 16'h0000;
    end else if (run) begin
      done_o <= 1'b0;
      // float time keeps running through internal cycles
      if (float_q != 3'h0 && st_q == S_IDLE)
        float_q <= float_q - 3'h1;
      case (st_q)
        S_IDLE: begin
          if (fifo_valid && need_fl)
            fl_seen_q <= 1'b1;
          if (fifo_pop) begin
            fl_seen_q <= 1'b0;
            wr_q   <= f_wr;
            cs_q   <= f_cs;
            addr_o <= fifo_out[41:18];
            data_o <= fifo_out[17:2];
            be_q   <= fifo_out[1:0];
            // counts only when enabled: loads n+1, giving n waits
            cnt_q  <= c_wse ? {1'b0, c_nws} + 4'h1 : 4'h0;
            st_q   <= (early_w || cs_w) ? S_PRE : S_XFER;
            half_q <= 1'b0;
          end
        end
        S_PRE: st_q <= S_XFER;
        S_XFER: begin
          if (!half_q)
            half_q <= 1'b1;
          else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          if (half_q && cnt_q <= 4'h1)
            st_q <= S_DONE;
        end
        S_DONE: begin
          // registered strobes are still low here, so the bus holds the read word
          if (!wr_q)
            rdata_o <= data_i;
          done_o    <= 1'b1;
          last_cs_q <= cs_q;
          last_rd_q <= ~wr_q;
          last_wr_q <= wr_q;
          any_ext_q <= 1'b1;
          float_q   <= wr_q ? 3'h0 : cur_tdf;
          st_q      <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // strobes registered; the half-cycle phase is modelled by half_q
  wire act  = (st_q == S_XFER);
  wire rd_a = act && !wr_q && (read_protocol_select_i || half_q);
  wire wr_a = act && wr_q && half_q;
  always @(posedge mclk_i) begin
    if (!resetn_i) begin
      chip_select_low_o      <= 8'hff;
      lower_byte_select_o    <= 1'b1;
      upper_byte_select_o    <= 1'b1;
      read_strobe_o          <= 1'b1;
      output_enable_strobe_o <= 1'b1;
      lower_write_strobe_o   <= 1'b1;
      upper_write_strobe_o   <= 1'b1;
      write_strobe_o         <= 1'b1;
      data_oe_o              <= 1'b0;
      wes_seen_q             <= 1'b0;
    end else if (run) begin
      chip_select_low_o      <= act ? ~(8'h01 << cs_q) : 8'hff;
      // byte-select mode drives the byte lanes, write strobe, output enable
      lower_byte_select_o    <= !(act && byte_sel && be_q[0]);
      upper_byte_select_o    <= !(act && byte_sel && be_q[1]);
      output_enable_strobe_o <= !(rd_a && byte_sel);
      write_strobe_o         <= !(wr_a && (byte_sel || !cur_wide));
      // byte-write mode: per-lane write strobes, single read strobe
      read_strobe_o          <= !(rd_a && !byte_sel);
      lower_write_strobe_o   <= !(wr_a && cur_wide && !byte_sel && be_q[0]);
      upper_write_strobe_o   <= !(wr_a && cur_wide && !byte_sel && be_q[1]);
      // data held until the pin low has passed all sync flops; a short pulse never
      // makes the stages agree, so the raw stages are watched instead
      wes_seen_q             <= !wr_a && data_oe_o && (wes_seen_q || !(&wes_sy_q));
      data_oe_o              <= wr_a || (data_oe_o && !(wes_seen_q && (&wes_sy_q)));
    end
  end
endmodule // ebus_access
`default_nettype wire

/* File: verification/ebus_access_sva.sv */
// assertions on the pins of the external bus access sequencer
`timescale 1ns/1ps
`default_nettype none
module ebus_access_sva (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        wait_request_n_i,
  input wire logic        write_strobe_pin_i,
  input wire logic        done_o,
  input wire logic        data_oe_o,
  input wire logic [7:0]  chip_select_low_o,
  input wire logic [23:0] addr_o,
  input wire logic        read_strobe_o,
  input wire logic        output_enable_strobe_o,
  input wire logic        lower_write_strobe_o,
  input wire logic        upper_write_strobe_o,
  input wire logic        write_strobe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire idle = &chip_select_low_o;
  wire rd   = !read_strobe_o || !output_enable_strobe_o;
  wire wr   = !lower_write_strobe_o || !upper_write_strobe_o || !write_strobe_o;
  // the request crosses three sync flops before the freeze takes hold
  sequence wait_held; !wait_request_n_i [*6]; endsequence
  sequence cs_moves; !idle ##1 $changed(chip_select_low_o); endsequence
  done_pulse_a: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  cs_single_a: assert property ($onehot0(~chip_select_low_o))
    else $error("two chip selects low");
  cs_change_a: assert property (cs_moves |-> idle)
    else $error("chip select switched with no gap");
  bw_mode_a: assert property (!lower_write_strobe_o || !upper_write_strobe_o |-> write_strobe_o)
    else $error("byte and common write strobe together");
  bs_mode_a: assert property (!output_enable_strobe_o |-> read_strobe_o)
    else $error("read and output enable together");
  strobe_cs_a: assert property (rd || wr |-> !idle)
    else $error("strobe without chip select");
  data_hold_a: assert property ($rose(write_strobe_pin_i) |-> data_oe_o)
    else $error("write data gone before strobe rose");
  wait_freeze_a: assert property (wait_held |=> $stable(chip_select_low_o) && $stable(addr_o) && !done_o)
    else $error("sequencer moved while waiting");
endmodule // ebus_access_sva
bind ebus_access ebus_access_sva chk (.*);
`default_nettype wire

/* File: verification/ebus_mem_model.sv */
// behavioural 16-bit memory standing on the external bus
`timescale 1ns/1ps
`default_nettype none
module ebus_mem_model (
  input  wire logic        mclk_i,
  input  wire logic        stall_i,
  input  wire logic [7:0]  chip_select_low_o,
  input  wire logic [23:0] addr_o,
  input  wire logic        read_strobe_o,
  input  wire logic        output_enable_strobe_o,
  input  wire logic        lower_write_strobe_o,
  input  wire logic        upper_write_strobe_o,
  input  wire logic        write_strobe_o,
  input  wire logic        lower_byte_select_o,
  input  wire logic        upper_byte_select_o,
  input  wire logic [15:0] data_o,
  output logic      [15:0] data_i,
  output logic             write_strobe_pin_i,
  output logic             wait_request_n_i
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q = 0;
  logic [7:0]  a_q;
  logic        up_q, lo_q;
  wire         sel = !(&chip_select_low_o);
  wire [7:0]   a   = addr_o[8:1];
  wire         up  = sel && (!upper_write_strobe_o || !write_strobe_o && !upper_byte_select_o);
  wire         lo  = sel && (!lower_write_strobe_o || !write_strobe_o && !lower_byte_select_o);
  // a released bus must not look like the last word read
  assign data_i = sel && !(read_strobe_o && output_enable_strobe_o) ? mem[a] : ~last_q;
  assign write_strobe_pin_i = write_strobe_o & lower_write_strobe_o & upper_write_strobe_o;
  assign wait_request_n_i = !stall_i;
  // data is taken as the strobe rises, so it must still be held then
  always @(posedge mclk_i) begin
    last_q <= data_i;
    up_q <= up;
    lo_q <= lo;
    a_q <= a;
    if (up_q && !up) mem[a_q][15:8] <= data_o[15:8];
    if (lo_q && !lo) mem[a_q][7:0] <= data_o[7:0];
  end
endmodule // ebus_mem_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the external bus access sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 0, resetn_i = 0, boot_width_pin_i = 0, read_protocol_select_i = 0, stall_i = 0, ce_i = 1;
  logic req_valid_i = 0, req_write_i = 0, remap_done_i = 0, cs0_cfg_written_i = 0, int_access_i = 0;
  logic [2:0] req_cs_i = 0;
  logic [1:0] req_be_i = 2'h3;
  logic [23:0] req_addr_i = 0, cfg_nws_i = 24'h000e10, cfg_tdf_i = 24'h000100, addr_o;
  logic [15:0] req_wdata_i = 0, rdata_o, data_i, data_o;
  logic [7:0] cfg_wse_i = 8'h06, cfg_bat_i = 8'h04, cfg_wide_i = 8'hff, chip_select_low_o;
  logic req_ready_o, int_ready_o, done_o, cs0_wide_o, cs0_base_active_o, lower_byte_select_o;
  logic upper_byte_select_o, read_strobe_o, output_enable_strobe_o, lower_write_strobe_o;
  logic upper_write_strobe_o, write_strobe_o, write_strobe_pin_i, data_oe_o, wait_request_n_i;
  int mismatches = 0, tests_run = 0, cyc = 0, n_wl = 0, n_we = 0;
  ebus_access uut (.*);
  ebus_mem_model mem (.*);
  initial forever #4 mclk_i = ~mclk_i;
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    n_wl <= n_wl + !lower_write_strobe_o;
    n_we <= n_we + !write_strobe_o;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // one request through the fifo; strobe low cycles are returned
  task automatic access(input logic w, input logic [2:0] c, input logic [15:0] d, input logic [1:0] be,
                        output int wl, output int we);
    int t;
    wl = n_wl;
    we = n_we;
    req_write_i = w;
    req_cs_i = c;
    req_addr_i = {20'h0, c, 1'b0};
    req_wdata_i = d;
    req_be_i = be;
    req_valid_i = 1;
    do @(posedge mclk_i); while (req_ready_o !== 1'b1);
    #1 req_valid_i = 0;
    for (t = 0; t < 100 && done_o !== 1'b1; t++) @(posedge mclk_i) #1;
    if (t == 100) check("done_seen", 0, 1);
    wl = n_wl - wl;
    we = n_we - we;
  endtask
  initial begin
    int wl, we;
    for (int b = 1; b >= 0; b--) begin
      boot_width_pin_i = b[0];
      resetn_i = 0;
      repeat (8) @(posedge mclk_i);
      #1 resetn_i = 1;
      repeat (2) @(posedge mclk_i);
      #1 check("cs0_wide", cs0_wide_o, !b[0]);
      check("cs_idle", chip_select_low_o, 8'hff);
    end
    for (int p = 0; p < 2; p++) begin
      read_protocol_select_i = p[0];
      access(1, 1, 16'ha5c3 + p, 2'h3, wl, we);
      check("cs1_wl_len", wl, 3);
      check("cs1_we_len", we, 0);
      access(1, 1, 16'h3c00, 2'h2, wl, we);
      access(0, 1, 0, 2'h3, wl, we);
      check("cs1_read", rdata_o, 16'h3cc3 + p);
      access(1, 2, 16'h1234, 2'h3, wl, we);
      check("cs2_we_len", we, 1);
      check("cs2_wl_len", wl, 0);
      access(1, 2, 16'h00ff, 2'h1, wl, we);
      access(0, 2, 0, 2'h3, wl, we);
      check("cs2_read", rdata_o, 16'h12ff);
      access(1, 3, 16'h0f0f, 2'h3, wl, we);
      check("cs3_wl_len", wl, 1);
    end
    fork
      access(0, 2, 0, 2'h3, wl, we);
      begin
        @(posedge mclk_i) #1 stall_i = 1;
        repeat (10) @(posedge mclk_i);
        #1 stall_i = 0;
      end
    join
    check("stalled_read", rdata_o, 16'h12ff);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
